// ===== hdl/alert_qualify_regs.svh
`ifndef ALERT_QUALIFY_REGS_SVH
`define ALERT_QUALIFY_REGS_SVH
// =====================================================================
// register indices (byte address = index * 4)
`define AQ_IDX_OP_COUNT  7'h46
`define AQ_IDX_OV_COUNT  7'h47
`define AQ_IDX_UV_COUNT  7'h48
`define AQ_IDX_ENABLE    7'h49
`define AQ_IDX_ACTIVE    7'h60
`define AQ_IDX_IRQ_STAT  7'h61
`define AQ_IDX_IRQ_MASK  7'h62
`define AQ_IDX_COMMAND   7'h63
// =====================================================================
// reset values and implemented bits
`define AQ_RST_COUNT     8'h00
`define AQ_RST_ENABLE    24'h000000
`define AQ_ENABLE_IMPL   24'hfffffe
// =====================================================================
// alert source bit positions (channel 1 sits at the group top)
`define AQ_BIT_OC        23
`define AQ_BIT_UC        19
`define AQ_BIT_OV        15
`define AQ_BIT_UV        11
`define AQ_BIT_OP        7
`define AQ_BIT_EN_ACCUM_OVERFLOW   3
`define AQ_BIT_ACC_FULL  2
`define AQ_BIT_CYC_DONE  1
`define AQ_BIT_UNUSED    0
// =====================================================================
// sample-count field layout and codes
`define AQ_FIELD_TOP     7
`define AQ_FIELD_W       2
`define AQ_NEED_CODE0    5'h01
`define AQ_NEED_CODE1    5'h04
`define AQ_NEED_CODE2    5'h08
`define AQ_NEED_CODE3    5'h10
// =====================================================================
// command register bits
`define AQ_CMD_REFRESH   0
`define AQ_CMD_REFRESH_V 1
`endif

// ===== hdl/alert_qualify_pkg.sv
package alert_qualify_pkg;
  // =====================================================================
  // raw alert conditions, element 0 is channel 1
  typedef struct packed {
    logic [3:0] hicur;
    logic [3:0] lowcur;
    logic [3:0] hivolt;
    logic [3:0] lowvolt;
    logic       en_accum_overflow;
    logic       acc_full;
    logic       cyc_done;
  } src_cond_t;

  // =====================================================================
  // bus answer state
  typedef enum {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// ===== hdl/sample_qualifier.sv
`timescale 1ns/1ps
`include "alert_qualify_regs.svh"
module sample_qualifier #(
  parameter int CNT_W = 5
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       sample_i,
  input  wire logic       cond_i,
  input  wire logic [1:0] sel_i,
  output logic            hit_o
);
  // =====================================================================
  // checks
  if (CNT_W < 5)
  begin : g_bad_width
    $error("counter too narrow for sixteen samples");
  end

  // =====================================================================
  // count decode
  function automatic logic [CNT_W-1:0] count_need(input logic [1:0] sel);
    logic [4:0] n;
    n = `AQ_NEED_CODE0;
    case (sel)
      2'h1:    n = `AQ_NEED_CODE1;
      2'h2:    n = `AQ_NEED_CODE2;
      2'h3:    n = `AQ_NEED_CODE3;
      default: n = `AQ_NEED_CODE0;
    endcase
    return CNT_W'(n);
  endfunction

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] need;
  logic             hit_nxt;

  // saturate so a lowered count code still qualifies at once
  assign need    = count_need(sel_i);
  assign cnt_nxt = !cond_i ? '0 : (cnt_r >= need) ? cnt_r : cnt_r + 1'b1;
  assign hit_nxt = cond_i && (cnt_nxt >= need);

  // state only moves on a completed conversion
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= '0;
      hit_o <= 1'b0;
    end
    else if (sample_i)
    begin
      cnt_r <= cnt_nxt;
      hit_o <= hit_nxt;
    end
  end

  // =====================================================================
  // assertions
  property p_restart;
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_i && !cond_i |=> !hit_o && (cnt_r == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted");

  property p_four;
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_i && cond_i && (sel_i == 2'h1) && (cnt_r == CNT_W'(3)) |=> hit_o;
  endproperty
  a_four: assert property (p_four) else $error("fourth sample did not qualify");

  property p_sixteen;
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_i && cond_i && (sel_i == 2'h3) && (cnt_r == CNT_W'(14)) && !hit_o |=> !hit_o;
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("qualified before sixteen");

  property p_single;
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_i && cond_i && (sel_i == 2'h0) |=> hit_o;
  endproperty
  a_single: assert property (p_single) else $error("single sample did not qualify");
endmodule

// ===== hdl/alert_qualify_enable.sv
// Operation
// - over-power needs 1/4/8/16 consecutive samples
// - over-voltage needs 1/4/8/16 consecutive samples
// - under-voltage needs 1/4/8/16 consecutive samples
// - channel 1 field on top, channel 4 lowest
// - count fields reset to zero, single sample
// - enable bit one enables; all reset zero
// - only enabled sources reach alert output
// - new enables active only after refresh
// - bits 23-20 over-current, 19-16 under-current
// - bits 15-12 OV, 11-8 UV, 7-4 OP
// - bits 3-1 accumulator, count, cycle; 0 zero
// - over-power compares magnitude against limit
`timescale 1ns/1ps
`include "alert_qualify_regs.svh"
module alert_qualify_enable #(
  parameter int NUM_CH = 4,
  parameter int PWR_W  = 24
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_i,
  input  wire logic [8:0]                   adr_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  input  wire logic                         we_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  output logic                              ack_o,
  input  wire logic                         conv_done_i,
  input  wire logic [NUM_CH-1:0][PWR_W-1:0] power_i,
  input  wire logic [NUM_CH-1:0][PWR_W-1:0] op_limit_i,
  input  wire alert_qualify_pkg::src_cond_t cond_i,
  output logic      [23:0]                  alert_src_o,
  output logic                              alert_o,
  output logic                              irq_o
);
  // =====================================================================
  // checks
  if (NUM_CH != 4)
  begin : g_bad_ch
    $error("register layout holds exactly four channels");
  end
  if (PWR_W < 2)
  begin : g_bad_pwr
    $error("power word too narrow");
  end

  // =====================================================================
  // helpers
  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        m[b*8 +: 8] = wd[b*8 +: 8];
    return m;
  endfunction

  // channel 1 holds the top field of a count register
  function automatic logic [1:0] field_sel(input logic [7:0] r, input int ch);
    return r[`AQ_FIELD_TOP - `AQ_FIELD_W*ch -: `AQ_FIELD_W];
  endfunction

  // magnitude test: beyond the limit in either direction
  function automatic logic over_mag(input logic [PWR_W-1:0] p, input logic [PWR_W-1:0] lim);
    logic signed [PWR_W:0] ps;
    logic signed [PWR_W:0] ls;
    ps = {p[PWR_W-1], p};
    ls = {lim[PWR_W-1], lim};
    if (ls < 0)
      ls = -ls;
    return (ps > ls) || (ps < -ls);
  endfunction

  // =====================================================================
  // registers
  logic [7:0]                  op_cnt_r;
  logic [7:0]                  ov_cnt_r;
  logic [7:0]                  uv_cnt_r;
  logic [23:0]                 enable_r;
  logic [23:0]                 active_r;
  logic [23:0]                 status_r;
  logic [23:0]                 mask_r;
  alert_qualify_pkg::bus_state_t bus_r;

  // =====================================================================
  // bus decode
  logic        req;
  logic        wr_go;
  logic        rd_go;
  logic [6:0]  idx;
  logic        hit_op;
  logic        hit_ov;
  logic        hit_uv;
  logic        hit_en;
  logic        hit_act;
  logic        hit_st;
  logic        hit_mk;
  logic        hit_cmd;
  logic        refresh;
  logic [31:0] rd_data;

  // one answer per request; the cycle after ack is idle
  assign req     = cyc_i && stb_i && (bus_r == alert_qualify_pkg::BUS_IDLE);
  assign wr_go   = req && we_i;
  assign rd_go   = req && !we_i;
  assign idx     = adr_i[8:2];
  assign hit_op  = idx == `AQ_IDX_OP_COUNT;
  assign hit_ov  = idx == `AQ_IDX_OV_COUNT;
  assign hit_uv  = idx == `AQ_IDX_UV_COUNT;
  assign hit_en  = idx == `AQ_IDX_ENABLE;
  assign hit_act = idx == `AQ_IDX_ACTIVE;
  assign hit_st  = idx == `AQ_IDX_IRQ_STAT;
  assign hit_mk  = idx == `AQ_IDX_IRQ_MASK;
  assign hit_cmd = idx == `AQ_IDX_COMMAND;
  // either refresh flavour activates the written enables
  assign refresh = wr_go && hit_cmd && sel_i[0] &&
                   (dat_i[`AQ_CMD_REFRESH] || dat_i[`AQ_CMD_REFRESH_V]);

  // unmapped reads answer zero, unmapped writes are dropped
  assign rd_data = hit_op  ? {24'h000000, op_cnt_r} :
                   hit_ov  ? {24'h000000, ov_cnt_r} :
                   hit_uv  ? {24'h000000, uv_cnt_r} :
                   hit_en  ? {8'h00, enable_r} :
                   hit_act ? {8'h00, active_r} :
                   hit_st  ? {8'h00, status_r} :
                   hit_mk  ? {8'h00, mask_r} : 32'h00000000;

  // =====================================================================
  // next register values
  logic [31:0] op_w;
  logic [31:0] ov_w;
  logic [31:0] uv_w;
  logic [31:0] en_w;
  logic [31:0] mk_w;
  logic [23:0] enable_nxt;
  logic [23:0] active_nxt;
  logic [23:0] mask_nxt;

  assign op_w       = merge32({24'h000000, op_cnt_r}, dat_i, sel_i);
  assign ov_w       = merge32({24'h000000, ov_cnt_r}, dat_i, sel_i);
  assign uv_w       = merge32({24'h000000, uv_cnt_r}, dat_i, sel_i);
  assign en_w       = merge32({8'h00, enable_r}, dat_i, sel_i);
  assign mk_w       = merge32({8'h00, mask_r}, dat_i, sel_i);
  assign enable_nxt = (wr_go && hit_en) ? (en_w[23:0] & `AQ_ENABLE_IMPL) : enable_r;
  assign active_nxt = refresh ? enable_r : active_r;
  assign mask_nxt   = (wr_go && hit_mk) ? (mk_w[23:0] & `AQ_ENABLE_IMPL) : mask_r;

  // settings, all zero from reset
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      op_cnt_r <= `AQ_RST_COUNT;
      ov_cnt_r <= `AQ_RST_COUNT;
      uv_cnt_r <= `AQ_RST_COUNT;
      enable_r <= `AQ_RST_ENABLE;
      active_r <= `AQ_RST_ENABLE;
      mask_r   <= `AQ_RST_ENABLE;
    end
    else
    begin
      op_cnt_r <= (wr_go && hit_op) ? op_w[7:0] : op_cnt_r;
      ov_cnt_r <= (wr_go && hit_ov) ? ov_w[7:0] : ov_cnt_r;
      uv_cnt_r <= (wr_go && hit_uv) ? uv_w[7:0] : uv_cnt_r;
      enable_r <= enable_nxt;
      active_r <= active_nxt;
      mask_r   <= mask_nxt;
    end
  end

  // bus answer: ack one cycle after the request, data with it
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_r <= alert_qualify_pkg::BUS_IDLE;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      case (bus_r)
        alert_qualify_pkg::BUS_IDLE:
          bus_r <= req ? alert_qualify_pkg::BUS_ACK : alert_qualify_pkg::BUS_IDLE;
        alert_qualify_pkg::BUS_ACK:
          bus_r <= alert_qualify_pkg::BUS_IDLE;
        default:
          bus_r <= alert_qualify_pkg::BUS_IDLE;
      endcase
      ack_o <= req;
      dat_o <= rd_go ? rd_data : 32'h00000000;
    end
  end

  // =====================================================================
  // qualification per channel
  logic [NUM_CH-1:0] op_cond;
  logic [NUM_CH-1:0] op_hit;
  logic [NUM_CH-1:0] ov_hit;
  logic [NUM_CH-1:0] uv_hit;

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    assign op_cond[ch] = over_mag(power_i[ch], op_limit_i[ch]);

    sample_qualifier #(.CNT_W(5)) u_op (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .sample_i  (conv_done_i),
      .cond_i    (op_cond[ch]),
      .sel_i     (field_sel(op_cnt_r, ch)),
      .hit_o     (op_hit[ch])
    );
    sample_qualifier #(.CNT_W(5)) u_ov (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .sample_i  (conv_done_i),
      .cond_i    (cond_i.hivolt[ch]),
      .sel_i     (field_sel(ov_cnt_r, ch)),
      .hit_o     (ov_hit[ch])
    );
    sample_qualifier #(.CNT_W(5)) u_uv (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .sample_i  (conv_done_i),
      .cond_i    (cond_i.lowvolt[ch]),
      .sel_i     (field_sel(uv_cnt_r, ch)),
      .hit_o     (uv_hit[ch])
    );
  end

  // =====================================================================
  // source vector, routing and interrupt
  logic [23:0] raw;
  logic [23:0] routed;
  logic [23:0] status_nxt;
  logic [23:0] st_clr;

  always_comb
  begin
    raw = '0;
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      raw[`AQ_BIT_OC - ch] = cond_i.hicur[ch];
      raw[`AQ_BIT_UC - ch] = cond_i.lowcur[ch];
      raw[`AQ_BIT_OV - ch] = ov_hit[ch];
      raw[`AQ_BIT_UV - ch] = uv_hit[ch];
      raw[`AQ_BIT_OP - ch] = op_hit[ch];
    end
    raw[`AQ_BIT_EN_ACCUM_OVERFLOW]  = cond_i.en_accum_overflow;
    raw[`AQ_BIT_ACC_FULL] = cond_i.acc_full;
    raw[`AQ_BIT_CYC_DONE] = cond_i.cyc_done;
  end

  // the pin sees the active set, not the freshly written one
  assign routed     = raw & active_r & `AQ_ENABLE_IMPL;
  assign st_clr     = (wr_go && hit_st) ? (dat_i[23:0] & {{8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}}) : 24'h000000;
  // a new rising source beats a write-one clear in the same cycle
  assign status_nxt = (status_r & ~st_clr) | (routed & ~alert_src_o);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      alert_src_o <= 24'h000000;
      alert_o     <= 1'b0;
      status_r    <= 24'h000000;
      irq_o       <= 1'b0;
    end
    else
    begin
      alert_src_o <= routed;
      alert_o     <= |routed;
      status_r    <= status_nxt;
      irq_o       <= |(status_nxt & mask_nxt); // new mask counts at once, no lag
    end
  end

  // =====================================================================
  // assertions
  property p_route_gated;
    @(posedge sys_clk_i) disable iff (rst_i)
    ##1 (alert_src_o & ~$past(active_r)) == 24'h000000;
  endproperty
  a_route_gated: assert property (p_route_gated) else $error("disabled source reached alert");

  property p_active_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    !refresh |=> $stable(active_r);
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("enables moved without refresh");

  property p_refresh_load;
    @(posedge sys_clk_i) disable iff (rst_i)
    refresh |=> active_r == $past(enable_r);
  endproperty
  a_refresh_load: assert property (p_refresh_load) else $error("refresh did not load enables");

  property p_oc_ch1;
    @(posedge sys_clk_i) disable iff (rst_i)
    cond_i.hicur[0] && active_r[23] |=> alert_src_o[23] && alert_o;
  endproperty
  a_oc_ch1: assert property (p_oc_ch1) else $error("over-current channel 1 not routed");

  property p_op_ch4;
    @(posedge sys_clk_i) disable iff (rst_i)
    op_hit[3] && active_r[4] |=> alert_src_o[4];
  endproperty
  a_op_ch4: assert property (p_op_ch4) else $error("over-power channel 4 not routed");

  property p_bit0_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    !enable_r[0] && !alert_src_o[0];
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("unimplemented enable bit set");

  property p_op_mag;
    @(posedge sys_clk_i) disable iff (rst_i)
    ($signed(power_i[0]) < -$signed(op_limit_i[0])) && !op_limit_i[0][PWR_W-1] |-> op_cond[0];
  endproperty
  a_op_mag: assert property (p_op_mag) else $error("negative over-power missed");

  property p_field_ch1;
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_go && hit_op && sel_i[0] |=> op_cnt_r[7:6] == $past(dat_i[7:6]);
  endproperty
  a_field_ch1: assert property (p_field_ch1) else $error("channel 1 field misplaced");

  property p_ack_once;
    @(posedge sys_clk_i) disable iff (rst_i)
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_irq;
    @(posedge sys_clk_i) disable iff (rst_i)
    ##1 irq_o == |(status_r & mask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt disagrees with status");
endmodule

// ===== verification/host_model.sv
`timescale 1ns/1ps
// =====================================================================
// host side: classic wishbone single cycles
module host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [8:0]       adr_o,
  output logic [31:0]      dat_o,
  output logic [3:0]       sel_o
);
  // idle bus from time zero
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 9'h000;
    dat_o = 32'h0;
    sel_o = 4'h0;
  end

  // one access; request stands until ack is seen at an edge
  task automatic access(input logic we, input logic [6:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
    @(posedge sys_clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= {idx, 2'b00};
    dat_o <= wd;
    sel_o <= 4'hf;
    // no cycle count assumed; only the bench watchdog ends a hang
    do
    begin
      @(posedge sys_clk_i);
    end
    while (ack_i !== 1'b1);
    rd = dat_i;
    ok = (ack_i === 1'b1);
    // released lines flip so a stale value cannot pass for a live one
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= ~we;
    adr_o <= ~{idx, 2'b00};
    dat_o <= ~wd;
    sel_o <= 4'h0;
  endtask
endmodule

// ===== verification/test_alert_qualify_enable.sv
`timescale 1ns/1ps
`include "alert_qualify_regs.svh"
module test_alert_qualify_enable;
  // =====================================================================
  // signals
  logic                           sys_clk_i;
  logic                           rst_i;
  logic                           cyc, stb, we, ack, alert, irq, conv_done;
  logic [8:0]                     adr;
  logic [31:0]                    wdat, rdat;
  logic [3:0]                     sel;
  logic [3:0][23:0]               power;
  logic [3:0][23:0]               op_lim;
  logic [23:0]                    alert_src;
  alert_qualify_pkg::src_cond_t   cond;
  int                             fail_count, checks_done;

  // =====================================================================
  // clock, reset and time-zero inputs
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    rst_i = 1'b1;
    conv_done = 1'b0;
    power = '0;
    op_lim = {24'h000064, 24'hffff9c, 24'hffff9c, 24'h000064};
    cond = '0;
    fail_count = 0;
    checks_done = 0;
  end

  host_model host (.sys_clk_i(sys_clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
                   .we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel));

  // limit magnitude fixed, sign mixed per channel; power swings on both sides of it
  alert_qualify_enable uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .conv_done_i(conv_done), .power_i(power), .op_limit_i(op_lim), .cond_i(cond),
    .alert_src_o(alert_src), .alert_o(alert), .irq_o(irq));

  // =====================================================================
  // tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        ok;
    host.access(1'b1, idx, d, rd, ok);
    cmp({31'h0, ok}, 32'h1);
  endtask

  task automatic rd_chk(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        ok;
    host.access(1'b0, idx, 32'h0, rd, ok);
    cmp({31'h0, ok}, 32'h1);
    cmp(rd, exp);
  endtask

  // off-edge wait so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic put_cond(input alert_qualify_pkg::src_cond_t c);
    @(posedge sys_clk_i);
    cond <= c;
    settle(2);
  endtask

  // one conversion: type 0 ov, 1 uv, 2 op; power sign alternates by channel
  task automatic conv(input int t, input int ch, input logic v);
    @(posedge sys_clk_i);
    case (t)
      0: cond.hivolt[ch] <= v;
      1: cond.lowvolt[ch] <= v;
      default: power[ch] <= v ? ((ch % 2) ? 24'h0000c8 : 24'hffff38) : 24'h000032;
    endcase
    conv_done <= 1'b1;
    @(posedge sys_clk_i);
    conv_done <= 1'b0;
    settle(1);
  endtask

  // hang guard, far above the under one thousand cycles the run needs
  initial
  begin
    #(40 * 20000);
    fail_count++;
    give_verdict();
  end

  // =====================================================================
  // main sequence
  initial
  begin
    logic [6:0]                   idx_list [9];
    alert_qualify_pkg::src_cond_t c;
    int                           n, b;
    idx_list = '{`AQ_IDX_OP_COUNT, `AQ_IDX_OV_COUNT, `AQ_IDX_UV_COUNT, `AQ_IDX_ENABLE,
                 `AQ_IDX_ACTIVE, `AQ_IDX_IRQ_STAT, `AQ_IDX_IRQ_MASK, `AQ_IDX_COMMAND, 7'h50};
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (idx_list[i]) rd_chk(idx_list[i], 32'h0);
    wr(7'h50, 32'hffffffff);
    rd_chk(7'h50, 32'h0);
    wr(`AQ_IDX_ACTIVE, 32'h00ffffff);
    rd_chk(`AQ_IDX_ACTIVE, 32'h0);
    // every cond_i condition raised while nothing is active; power stays zero
    put_cond('1);
    cmp({8'h0, alert_src}, 32'h0);
    cmp({31'h0, alert}, 32'h0);
    c = '0;
    c.hicur = 4'hf;
    c.lowcur = 4'hf;
    c.en_accum_overflow = 1'b1;
    c.acc_full = 1'b1;
    c.cyc_done = 1'b1;
    put_cond(c);
    wr(`AQ_IDX_ENABLE, 32'hffffffff);
    rd_chk(`AQ_IDX_ENABLE, 32'h00fffffe);
    rd_chk(`AQ_IDX_ACTIVE, 32'h0);
    cmp({8'h0, alert_src}, 32'h0);
    wr(`AQ_IDX_COMMAND, 32'h1);
    settle(2);
    cmp({8'h0, alert_src}, 32'h00ff000e);
    rd_chk(`AQ_IDX_ACTIVE, 32'h00fffffe);
    rd_chk(`AQ_IDX_COMMAND, 32'h0);
    // interrupt: sticky status, mask, write-one-to-clear
    cmp({31'h0, irq}, 32'h0);
    wr(`AQ_IDX_IRQ_MASK, 32'h2);
    settle(2);
    cmp({31'h0, irq}, 32'h1);
    put_cond('0);
    rd_chk(`AQ_IDX_IRQ_STAT, 32'h00ff000e);
    wr(`AQ_IDX_IRQ_STAT, 32'h00ffffff);
    settle(2);
    cmp({31'h0, irq}, 32'h0);
    rd_chk(`AQ_IDX_IRQ_STAT, 32'h0);
    // each level source alone lands on its own enable bit
    for (int i = 0; i < 11; i++)
    begin
      c = '0;
      case (i)
        8: c.en_accum_overflow = 1'b1;
        9: c.acc_full = 1'b1;
        10: c.cyc_done = 1'b1;
        default: if (i < 4) c.hicur[i] = 1'b1; else c.lowcur[i - 4] = 1'b1;
      endcase
      b = (i < 4) ? 23 - i : (i < 8) ? 23 - i : 11 - i;
      put_cond(c);
      cmp({8'h0, alert_src}, 32'h1 << b);
      cmp({31'h0, alert}, 32'h1);
    end
    put_cond('0);
    // counts change only with enables off; code k on channel k+1
    wr(`AQ_IDX_ENABLE, 32'h0);
    wr(`AQ_IDX_COMMAND, 32'h1);
    wr(`AQ_IDX_OP_COUNT, 32'h1b);
    wr(`AQ_IDX_OV_COUNT, 32'h1b);
    wr(`AQ_IDX_UV_COUNT, 32'h1b);
    rd_chk(`AQ_IDX_UV_COUNT, 32'h1b);
    wr(`AQ_IDX_ENABLE, 32'h00ffffff);
    wr(`AQ_IDX_COMMAND, 32'h1);
    for (int t = 0; t < 3; t++)
      for (int k = 0; k < 4; k++)
      begin
        n = (k == 0) ? 1 : 2 << k;
        b = (t == 0) ? 15 - k : (t == 1) ? 11 - k : 7 - k;
        conv(t, k, 1'b0);
        repeat (n - 1) conv(t, k, 1'b1);
        conv(t, k, 1'b0);
        repeat (n - 1) conv(t, k, 1'b1);
        cmp({8'h0, alert_src}, 32'h0);
        conv(t, k, 1'b1);
        cmp({8'h0, alert_src}, 32'h1 << b);
        cmp({31'h0, alert}, 32'h1);
        conv(t, k, 1'b0);
        cmp({8'h0, alert_src}, 32'h0);
      end
    // staged disable keeps routing until the second refresh flavour
    c = '0;
    c.hicur = 4'h8;
    put_cond(c);
    wr(`AQ_IDX_ENABLE, 32'h0);
    settle(1);
    cmp({8'h0, alert_src}, 32'h00100000);
    wr(`AQ_IDX_COMMAND, 32'h2);
    settle(2);
    cmp({8'h0, alert_src}, 32'h0);
    rd_chk(`AQ_IDX_ACTIVE, 32'h0);
    give_verdict();
  end
endmodule
